// [dv/ortc_ecu.sv]
// Vehicle unit model: answers each request with a run of evenly spaced replies.
`timescale 1ns/1ns
module ortc_ecu (
    input  wire        clk,
    input  wire        start,
    input  wire [3:0]  n_rep,
    input  wire [15:0] gap,
    output reg         rx
);
    reg [3:0]  k_q = 4'hf;
    reg [15:0] t_q = 16'h0;
    initial rx = 1'b0;
    always @(posedge clk)
    begin
        rx <= 1'b0;
        t_q <= t_q + 16'h1;
        if (start)
        begin
            k_q <= 4'h0;
            t_q <= 16'h1;
        end
        else if (k_q < n_rep && t_q == gap)
        begin
            rx <= 1'b1;
            k_q <= k_q + 4'h1;
            t_q <= 16'h1;
        end
    end
endmodule // ortc_ecu

// [dv/ortc_sva.sv]
// Checker for the response timeout controller ports.
`timescale 1ns/1ns
module ortc_sva (
    input wire       CLK_SYS,
    input wire       RST,
    input wire       RD,
    input wire       REQ_SENT,
    input wire [7:0] RDATA,
    input wire       BUSY,
    input wire       DONE,
    input wire       NO_DATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_phase_start: assert property (REQ_SENT && !BUSY |=> BUSY)
        else $error("no start");
    a_idle_stays: assert property (!BUSY && !REQ_SENT |=> !BUSY)
        else $error("idle rise");
    a_end_flagged: assert property ($fell(BUSY) |-> DONE || NO_DATA)
        else $error("silent end");
    a_flag_ends: assert property (DONE || NO_DATA |-> !BUSY && $past(BUSY))
        else $error("flag off end");
    a_done_once: assert property (DONE |=> !DONE [*2])
        else $error("long done");
    a_nodata_once: assert property (NO_DATA |=> !NO_DATA)
        else $error("long nodata");
    a_end_excl: assert property (!(DONE && NO_DATA))
        else $error("both flags");
    a_read_quiet: assert property (!RD |=> RDATA == 8'h00)
        else $error("stray data");
endmodule // ortc_sva
bind ortc_top ortc_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST), .RD(RD), .REQ_SENT(REQ_SENT),
    .RDATA(RDATA), .BUSY(BUSY), .DONE(DONE), .NO_DATA(NO_DATA));

// [dv/ortc_tb_top.sv]
// Self-checking bench for the response timeout controller.
`timescale 1ns/1ns
module ortc_tb_top;
    reg        clk, rst, wr, rd, req;
    reg [3:0]  addr, cnt, n_rep;
    reg [7:0]  wdata, rv;
    reg [15:0] gap;
    wire [7:0] rdata;
    wire       reply, busy, done, no_data, irq;
    integer    failures, num_checks, cyc;
    ortc_top #(.TICK_CYC(10)) u_dut (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .REQ_SENT(req), .REQ_COUNT(cnt),
        .REPLY_RX(reply), .BUSY(busy), .DONE(done), .NO_DATA(no_data), .IRQ(irq));
    ortc_ecu u_ecu (.clk(clk), .start(req), .n_rep(n_rep), .gap(gap), .rx(reply));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input ok, input [7:0] got);
    begin
        num_checks = num_checks + 1;
        if (ok !== 1'b1)
        begin
            failures = failures + 1;
            $display("[FAIL] %0t got %h", $time, got);
        end
    end
    endtask
    task bw(input [3:0] a, input [7:0] d);
    begin
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    end
    endtask
    task br(input [3:0] a, input [7:0] m, input [7:0] e);
    begin
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
        chk((rv & m) === e, rv);
        @(posedge clk);
    end
    endtask
    // Starts a phase and waits, bounded, for its end flag to show.
    task go(input [3:0] c, input [3:0] n, input [15:0] g, input integer lim);
    begin
        cnt <= c;
        n_rep <= n;
        gap <= g;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        cyc = 0;
        #1;
        while ((done | no_data) !== 1'b1 && cyc < lim)
        begin
            @(posedge clk);
            #1 cyc = cyc + 1;
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    initial
    begin
        failures = 0;
        num_checks = 0;
        {rst, wr, rd, req} = 4'h8;
        {addr, cnt, n_rep, wdata, gap} = 36'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        br(4'h1, 8'hff, 8'h32);
        br(4'h0, 8'hff, 8'h01);
        br(4'hf, 8'hff, 8'h00);
        bw(4'h3, 8'h0f);
        bw(4'h6, 8'h01);
        br(4'h0, 8'hff, 8'h00);
        go(4'h0, 4'h0, 16'h0, 600);
        chk(no_data === 1'b1 && cyc > 489 && cyc < 511, cyc[7:0]);
        br(4'h2, 8'hff, 8'h01);
        chk(irq === 1'b1, rv);
        bw(4'h2, 8'h01);
        #1 chk(irq === 1'b0, rv);
        $display("test no data done");
        go(4'h0, 4'h2, 16'd300, 1200);
        chk(done === 1'b1 && cyc > 1089 && cyc < 1111, cyc[7:0]);
        br(4'h2, 8'hff, 8'h0a);
        br(4'h4, 8'hff, 8'h32);
        bw(4'h2, 8'h0f);
        go(4'h2, 4'h2, 16'd30, 100);
        chk(done === 1'b1 && cyc > 55 && cyc < 66, cyc[7:0]);
        br(4'h2, 8'hff, 8'h0c);
        bw(4'h2, 8'h0f);
        $display("test replies done");
        bw(4'h3, 8'h00);
        bw(4'h6, 8'h08);
        br(4'h0, 8'hff, 8'h04);
        go(4'h0, 4'h0, 16'h0, 3000);
        chk(no_data === 1'b1 && cyc > 2489 && cyc < 2511, cyc[7:0]);
        #1 chk(irq === 1'b0, rv);
        bw(4'h3, 8'h0f);
        #1 chk(irq === 1'b1, rv);
        bw(4'h6, 8'h10);
        br(4'h0, 8'hff, 8'h00);
        bw(4'h2, 8'h0f);
        $display("test multiplier done");
        bw(4'h6, 8'h04);
        br(4'h0, 8'hff, 8'h03);
        bw(4'h6, 8'h02);
        br(4'h0, 8'hff, 8'h01);
        go(4'h0, 4'h2, 16'd100, 800);
        chk(done === 1'b1, cyc[7:0]);
        br(4'h5, 8'h00, 8'h00);
        chk(rv > 8'h11 && rv < 8'h15, rv);
        br(4'h4, 8'h00, 8'h00);
        chk(rv > 8'h1c && rv < 8'h21, rv);
        bw(4'h6, 8'h04);
        go(4'h0, 4'h2, 16'd100, 800);
        chk(done === 1'b1 && cyc > 480 && cyc < 560, cyc[7:0]);
        br(4'h4, 8'h00, 8'h00);
        chk(rv > 8'h16 && rv < 8'h1c, rv);
        bw(4'h1, 8'h00);
        br(4'h1, 8'hff, 8'h32);
        bw(4'h0, 8'h00);
        br(4'h4, 8'hff, 8'h32);
        $display("test adaptive done");
        end_of_test;
    end
    initial
    begin
        #400000;
        failures = failures + 1;
        end_of_test;
    end
endmodule // ortc_tb_top

// [verilog/ortc_map.vh]
// Constants for the response timeout controller.
// Behaviour
// - After a request, wait for a reply at most the timeout, default 200 ms.
// - Timer expiry with no reply ends waiting and reports no data.
// - Each reply restarts the timer; the phase ends on a quiet expiry or when a nonzero expected count is reached.
// - Adaptive mode, on by default, sets the timeout from measured reply latency.
// - Host can switch adaptive off, or pick a more aggressive adaptive setting.
// - Adaptive sizing follows the slowest responder so late replies survive.
// - A nonzero expected count finishes as soon as that many replies arrive.
// - Optional times-five multiplier lengthens the timeout; times-one restores it.
`ifndef ORTC_MAP_VH
`define ORTC_MAP_VH
`define ORTC_CLK_HZ         50000000
`define ORTC_TICK_US        4000
`define ORTC_TICK_CYC       ((`ORTC_CLK_HZ / 1000000) * `ORTC_TICK_US)
`define ORTC_ST_DEFAULT     8'h32
`define ORTC_ST_MIN         8'h08
`define ORTC_ADDR_CTRL      4'h0
`define ORTC_ADDR_SETTING   4'h1
`define ORTC_ADDR_STATUS    4'h2
`define ORTC_ADDR_MASK      4'h3
`define ORTC_ADDR_CURRENT   4'h4
`define ORTC_ADDR_MEASURED  4'h5
`define ORTC_ADDR_CMD       4'h6
`define ORTC_CMD_AT_OFF     0
`define ORTC_CMD_AT_ON      1
`define ORTC_CMD_AT_AGGR    2
`define ORTC_CMD_TM5        3
`define ORTC_CMD_TM1        4
`define ORTC_EV_NODATA      0
`define ORTC_EV_DONE        1
`define ORTC_EV_COUNT       2
`define ORTC_EV_REPLY       3
`endif

// [verilog/ortc_top.v]
// Response timeout controller: waits for vehicle replies after each request.
`timescale 1ns/1ns
`include "ortc_map.vh"
module ortc_top #(
    parameter TICK_CYC = `ORTC_TICK_CYC
) (
    input  wire       CLK_SYS,
    input  wire       RST,
    input  wire [3:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    input  wire       REQ_SENT,
    input  wire [3:0] REQ_COUNT,
    input  wire       REPLY_RX,
    output reg        BUSY,
    output reg        DONE,
    output reg        NO_DATA,
    output reg        IRQ
);
    localparam S_IDLE = 1'b0;
    localparam S_WAIT = 1'b1;

    reg        state_q;
    reg [19:0] tick_cnt_q;
    reg        tick;
    reg [7:0]  setting_q;
    reg        adapt_on_q;
    reg        adapt_aggr_q;
    reg        times_five_q;
    reg [7:0]  adapt_q;
    reg [7:0]  lat_q;
    reg [7:0]  max_lat_q;
    reg [10:0] timer_q;
    reg [3:0]  want_q;
    reg [3:0]  got_q;
    reg        any_q;
    reg [3:0]  status_q;
    reg [3:0]  mask_q;
    reg [7:0]  base;
    reg [10:0] limit;
    reg [3:0]  ev;
    reg [7:0]  meas;
    wire       wr_ctrl = WR && ADDR == `ORTC_ADDR_CTRL;
    wire       wr_cmd  = WR && ADDR == `ORTC_ADDR_CMD;

    // A 4 ms tick keeps the timeout counters narrow.
    always @(posedge CLK_SYS)
    begin
        if (RST || state_q == S_IDLE || tick_cnt_q == TICK_CYC - 1)
            tick_cnt_q <= 20'h00000;
        else
            tick_cnt_q <= tick_cnt_q + 20'h00001;
    end

    always @*
    begin
        tick = (state_q == S_WAIT) && (tick_cnt_q == TICK_CYC - 1);
        if (adapt_on_q)
            base = adapt_q;
        else
            base = setting_q;
        if (times_five_q)
            limit = {3'h0, base} + {1'b0, base, 2'h0};
        else
            limit = {3'h0, base};
        // Aggressive mode keeps a quarter of margin; plain keeps a half.
        if (adapt_aggr_q)
            meas = max_lat_q + {2'h0, max_lat_q[7:2]} + 8'h01;
        else
            meas = max_lat_q + {1'b0, max_lat_q[7:1]} + 8'h02;
        if (max_lat_q > 8'h9f)
            meas = 8'hff;
        if (meas < `ORTC_ST_MIN)
            meas = `ORTC_ST_MIN;
        if (meas > setting_q)
            meas = setting_q;
        ev = 4'h0;
        if (state_q == S_WAIT)
        begin
            if (REPLY_RX)
            begin
                ev[`ORTC_EV_REPLY] = 1'b1;
                if (want_q != 4'h0 && got_q + 4'h1 == want_q)
                    ev[`ORTC_EV_COUNT] = 1'b1;
            end
            else if (tick && timer_q + 11'h001 >= limit)
            begin
                if (any_q)
                    ev[`ORTC_EV_DONE] = 1'b1;
                else
                    ev[`ORTC_EV_NODATA] = 1'b1;
            end
        end
    end

    always @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_q      <= S_IDLE;
            timer_q      <= 11'h000;
            want_q       <= 4'h0;
            got_q        <= 4'h0;
            any_q        <= 1'b0;
            lat_q        <= 8'h00;
            max_lat_q    <= 8'h00;
            adapt_q      <= `ORTC_ST_DEFAULT;
            BUSY         <= 1'b0;
            DONE         <= 1'b0;
            NO_DATA      <= 1'b0;
        end
        else
        begin
            DONE    <= 1'b0;
            NO_DATA <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (REQ_SENT)
                    begin
                        state_q   <= S_WAIT;
                        timer_q   <= 11'h000;
                        want_q    <= REQ_COUNT;
                        got_q     <= 4'h0;
                        any_q     <= 1'b0;
                        lat_q     <= 8'h00;
                        max_lat_q <= 8'h00;
                        BUSY      <= 1'b1;
                    end
                end
                S_WAIT:
                begin
                    if (tick && lat_q != 8'hff)
                        lat_q <= lat_q + 8'h01;
                    if (REPLY_RX)
                    begin
                        timer_q <= 11'h000;
                        got_q   <= got_q + 4'h1;
                        any_q   <= 1'b1;
                        if (lat_q > max_lat_q)
                            max_lat_q <= lat_q;
                    end
                    else if (tick)
                        timer_q <= timer_q + 11'h001;
                    if (ev[`ORTC_EV_COUNT] || ev[`ORTC_EV_DONE] || ev[`ORTC_EV_NODATA])
                    begin
                        state_q <= S_IDLE;
                        BUSY    <= 1'b0;
                        DONE    <= ~ev[`ORTC_EV_NODATA];
                        NO_DATA <= ev[`ORTC_EV_NODATA];
                        // Only a quiet expiry means every responder was heard.
                        if (ev[`ORTC_EV_DONE])
                            adapt_q <= meas;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
            if (wr_ctrl && ~WDATA[0])
                adapt_q <= setting_q;
        end
    end

    always @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            setting_q    <= `ORTC_ST_DEFAULT;
            adapt_on_q   <= 1'b1;
            adapt_aggr_q <= 1'b0;
            times_five_q <= 1'b0;
            status_q     <= 4'h0;
            mask_q       <= 4'h0;
            IRQ          <= 1'b0;
            RDATA        <= 8'h00;
        end
        else
        begin
            if (WR && ADDR == `ORTC_ADDR_SETTING)
                setting_q <= (WDATA == 8'h00) ? `ORTC_ST_DEFAULT : WDATA;
            if (wr_ctrl)
            begin
                adapt_on_q   <= WDATA[0];
                adapt_aggr_q <= WDATA[1];
                times_five_q <= WDATA[2];
            end
            if (wr_cmd)
            begin
                if (WDATA[`ORTC_CMD_AT_OFF])
                    adapt_on_q <= 1'b0;
                if (WDATA[`ORTC_CMD_AT_ON])
                begin
                    adapt_on_q   <= 1'b1;
                    adapt_aggr_q <= 1'b0;
                end
                if (WDATA[`ORTC_CMD_AT_AGGR])
                begin
                    adapt_on_q   <= 1'b1;
                    adapt_aggr_q <= 1'b1;
                end
                if (WDATA[`ORTC_CMD_TM5])
                    times_five_q <= 1'b1;
                if (WDATA[`ORTC_CMD_TM1])
                    times_five_q <= 1'b0;
            end
            // Set wins over a simultaneous write-one clear.
            if (WR && ADDR == `ORTC_ADDR_STATUS)
                status_q <= (status_q & ~WDATA[3:0]) | ev;
            else
                status_q <= status_q | ev;
            if (WR && ADDR == `ORTC_ADDR_MASK)
                mask_q <= WDATA[3:0];
            IRQ <= |(status_q & mask_q);
            RDATA <= 8'h00;
            if (RD)
            begin
                case (ADDR)
                    `ORTC_ADDR_CTRL:     RDATA <= {5'h00, times_five_q, adapt_aggr_q, adapt_on_q};
                    `ORTC_ADDR_SETTING:  RDATA <= setting_q;
                    `ORTC_ADDR_STATUS:   RDATA <= {4'h0, status_q};
                    `ORTC_ADDR_MASK:     RDATA <= {4'h0, mask_q};
                    `ORTC_ADDR_CURRENT:  RDATA <= base;
                    `ORTC_ADDR_MEASURED: RDATA <= max_lat_q;
                    default:             RDATA <= 8'h00;
                endcase
            end
        end
    end
endmodule // ortc_top
